// ---- shared/sp_pkg.sv ----
// Purpose: Constants and types shared by the serial port design files
// Assumes: Register index times four gives the APB byte address
// Notes:   Clock divider counts are in cycles of the 40 MHz system clock; OVS counts ticks per bit
package sp_pkg;
    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [9:0] IDX_CTRL = 10'h098;
    localparam logic [9:0] IDX_BUF = 10'h099;
    localparam logic [9:0] IDX_RELL = 10'h0aa;
    localparam logic [9:0] IDX_RELH = 10'h0ba;
    localparam logic [9:0] IDX_RSEL = 10'h0d8;
    localparam logic [9:0] IDX_AUX = 10'h0e0;
    localparam logic [9:0] IDX_ISTS = 10'h0e1;
    localparam logic [9:0] IDX_IMASK = 10'h0e2;
    // ==========================================================
    // Values after reset
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_BUF = 8'h00;
    localparam logic [7:0] RST_RELL = 8'hd9;
    localparam logic [7:0] RST_RELH = 8'h03;
    localparam logic [7:0] RST_RSEL = 8'h00;
    localparam logic [7:0] RST_AUX = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;
    // ==========================================================
    // Field positions
    localparam int CTRL_MODE_LSB = 6;
    localparam int CTRL_MPROC = 5;
    localparam int CTRL_REN = 4;
    localparam int CTRL_TB8 = 3;
    localparam int CTRL_RB8 = 2;
    localparam int CTRL_TI = 1;
    localparam int CTRL_RI = 0;
    localparam int RSEL_BD = 7;
    localparam int AUX_DBL = 0;
    // ==========================================================
    // Modes of the mode field
    typedef enum logic [1:0] {
        SP_MODE_SHIFT = 2'b00,
        SP_MODE_UART8 = 2'b01,
        SP_MODE_FIX9 = 2'b10,
        SP_MODE_VAR9 = 2'b11
    } sp_mode_t;
    // ==========================================================
    // Cycle counts
    localparam int M0_DIV = 12;
    localparam logic [3:0] M0_LAST = 4'(M0_DIV - 1);
    localparam logic [3:0] M0_HALF = 4'(M0_DIV / 2);
    localparam logic [3:0] M0_SAMPLE = 4'(M0_DIV / 2 - 1);
    localparam int OVS = 16;
    localparam logic [3:0] SUB_LAST = 4'(OVS - 1);
    localparam logic [3:0] SUB_MID = 4'(OVS / 2 - 1);
    localparam int FIX_DIV_SLOW = 64;
    localparam int FIX_DIV_FAST = 32;
    localparam logic [1:0] PRE_SLOW_LAST = 2'(FIX_DIV_SLOW / OVS - 1);
    localparam logic [1:0] PRE_FAST_LAST = 2'(FIX_DIV_FAST / OVS - 1);
    localparam logic [9:0] GEN_TOP = 10'h3ff;
    localparam logic [3:0] M0_BIT_LAST = 4'h7;
    localparam logic [3:0] STOP_IDX8 = 4'h9;
    localparam logic [3:0] STOP_IDX9 = 4'ha;
    // ==========================================================
    // Engine states
    typedef enum logic [2:0] {
        SP_ST_IDLE = 3'b001,
        SP_ST_SHIFT = 3'b010,
        SP_ST_FRAME = 3'b100
    } sp_st_t;
endpackage

// ---- hdl/sp_rate_gen.sv ----
// Purpose: Sixteen-times bit-rate tick for the asynchronous modes
// Assumes: Timer overflow is a one-cycle pulse on the system clock
// Notes:   Tick is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
module sp_rate_gen (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_fixed,
    input wire logic i_dbl,
    input wire logic i_bd,
    input wire logic [9:0] i_reload,
    input wire logic i_timer_ovf,
    output logic o_tick
);
    logic [1:0] pre_r;
    logic [9:0] cnt_r;
    logic half_r;
    logic pre_evt;
    logic gen_wrap;

    // ==========================================================
    // Prescaler: 64 or 32 clocks per bit, sixteen ticks per bit
    assign pre_evt = (pre_r == (i_dbl ? sp_pkg::PRE_FAST_LAST : sp_pkg::PRE_SLOW_LAST));
    assign gen_wrap = pre_evt && (cnt_r == sp_pkg::GEN_TOP);

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            pre_r <= 2'h0;
        end else if (pre_evt) begin
            pre_r <= 2'h0;
        end else begin
            pre_r <= pre_r + 2'h1;
        end
    end

    // Reload counter counts up to the top, then reloads
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_r <= 10'h000;
        end else if (gen_wrap) begin
            cnt_r <= i_reload; // RQ12
        end else if (pre_evt) begin
            cnt_r <= cnt_r + 10'h001;
        end
    end

    // Overflow halver when rate doubling is off
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            half_r <= 1'b0;
        end else if (i_timer_ovf) begin
            half_r <= ~half_r;
        end
    end

    // Source select and tick register
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_tick <= 1'b0;
        end else if (i_fixed) begin
            o_tick <= pre_evt; // RQ2
        end else if (i_bd) begin
            o_tick <= gen_wrap; // RQ11
        end else begin
            o_tick <= i_timer_ovf && (i_dbl || half_r); // RQ11
        end
    end

    a_fixed_slow: assert property ( // RQ2
        @(posedge i_sys_clk) disable iff (i_reset || !i_fixed || i_dbl)
        (o_tick && $past(i_fixed)) |=> !o_tick [*3] ##1 o_tick)
        else $error("fixed slow tick spacing wrong");
    a_gen_reload: assert property ( // RQ12
        @(posedge i_sys_clk) disable iff (i_reset)
        (!i_fixed && i_bd && gen_wrap) |=> (o_tick && cnt_r == $past(i_reload)))
        else $error("generator reload or tick wrong");
endmodule // sp_rate_gen

// ---- hdl/sp_serial_port.sv ----
// Purpose: Serial port with shift mode, 8 and 9 bit UART, APB registers
// Assumes: APB master on the system clock; receive pin is asynchronous
// Notes:   Tags mark the logic that carries each rule
// Operation
// [RQ1] Mode field selects shift, 8-bit, two 9-bit
// [RQ2] Fixed 9-bit rate is clock/64 or /32
// [RQ3] Receiver accepts frames only while enabled
// [RQ4] Ninth sent bit comes from control bit 3
// [RQ5] Ninth received bit lands in control bit 2
// [RQ6] Transmit flag set at bit 8 end/stop start
// [RQ7] Receive flag set at bit 8/mid stop
// [RQ8] Buffer write loads and starts transmission
// [RQ9] Buffer read returns separate receive buffer
// [RQ10] Reload is 8 low plus 2 high bits
// [RQ11] Select bit chooses generator or timer overflow
// [RQ12] Generator rate follows the reload formula
// [RQ13] Software picks reload values for common rates
// [RQ14] Software prefers generator over timer overflow
// [RQ15] Software sets pin directions before use
// [RQ16] All timing comes from the core clock
// [RQ17] Frame: start low, LSB first, stop high
// [RQ18] Filter bit passes only ninth-bit-one frames
`timescale 1ns/1ps
module sp_serial_port (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_timer_ovf,
    input wire logic i_rxd,
    output logic o_txd,
    output logic o_rxd_out,
    output logic o_rxd_oe,
    output logic o_irq
);
    logic [1:0] mode_r;
    logic mproc_r, ren_r, tb8_r, rb8_r, ti_r, ri_r;
    logic [7:0] rell_r, relh_r, rsel_r, aux_r, rxbuf_r, rd_val;
    logic [1:0] ists_r, imask_r;
    logic rxd_m_r, rxd_s_r, rxd_prev_r;
    logic [3:0] m0_cnt_r, tx_bit_r, tx_sub_r, rx_bit_r, rx_sub_r, stop_idx;
    logic [10:0] tx_fr_r;
    logic [8:0] rx_sh_r;
    sp_pkg::sp_st_t tx_st_r, rx_st_r;
    logic acc, done, wr_done, rd_done, algn, hit, tick, m0_step, m0_start;
    logic wr_ctrl, wr_buf, rd_ists, ti_set, rx_done, rx_keep, ri_set, nine;
    logic [9:0] idx;

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);

    // ==========================================================
    // APB slave: one wait state, registered read data
    assign acc = i_psel && i_penable;
    assign done = acc && o_pready;
    assign wr_done = done && i_pwrite;
    assign rd_done = done && !i_pwrite;
    assign idx = i_paddr[11:2];
    assign algn = (i_paddr[1:0] == 2'b00);
    assign wr_ctrl = wr_done && hit && (idx == sp_pkg::IDX_CTRL);
    assign wr_buf = wr_done && hit && (idx == sp_pkg::IDX_BUF);
    assign rd_ists = rd_done && hit && (idx == sp_pkg::IDX_ISTS);

    // Read mux and address decode
    always_comb begin
        rd_val = 8'h00;
        hit = 1'b1;
        if (!algn) begin
            hit = 1'b0;
        end else if (idx == sp_pkg::IDX_CTRL) begin
            rd_val = {mode_r, mproc_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
        end else if (idx == sp_pkg::IDX_BUF) begin
            rd_val = rxbuf_r; // RQ9
        end else if (idx == sp_pkg::IDX_RELL) begin
            rd_val = rell_r;
        end else if (idx == sp_pkg::IDX_RELH) begin
            rd_val = relh_r;
        end else if (idx == sp_pkg::IDX_RSEL) begin
            rd_val = rsel_r;
        end else if (idx == sp_pkg::IDX_AUX) begin
            rd_val = aux_r;
        end else if (idx == sp_pkg::IDX_ISTS) begin
            rd_val = {6'h00, ists_r};
        end else if (idx == sp_pkg::IDX_IMASK) begin
            rd_val = {6'h00, imask_r};
        end else begin
            hit = 1'b0;
        end
    end

    // Bus answer registers
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= acc && !o_pready;
            if (acc && !o_pready) begin
                o_prdata <= {24'h00_0000, rd_val};
                o_pslverr <= !hit;
            end else begin
                o_pslverr <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Software registers
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            rell_r <= sp_pkg::RST_RELL;
            relh_r <= sp_pkg::RST_RELH;
            rsel_r <= sp_pkg::RST_RSEL;
            aux_r <= sp_pkg::RST_AUX;
            imask_r <= sp_pkg::RST_IRQ;
        end else if (wr_done && hit) begin
            if (idx == sp_pkg::IDX_RELL) begin
                rell_r <= i_pwdata[7:0];
            end else if (idx == sp_pkg::IDX_RELH) begin
                relh_r <= i_pwdata[7:0];
            end else if (idx == sp_pkg::IDX_RSEL) begin
                rsel_r <= i_pwdata[7:0];
            end else if (idx == sp_pkg::IDX_AUX) begin
                aux_r <= i_pwdata[7:0];
            end else if (idx == sp_pkg::IDX_IMASK) begin
                imask_r <= i_pwdata[1:0];
            end
        end
    end

    // Control register; hardware set of the flags wins over a clear
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            {mode_r, mproc_r, ren_r, tb8_r, rb8_r, ti_r, ri_r} <= sp_pkg::RST_CTRL;
        end else begin
            if (wr_ctrl) begin
                mode_r <= i_pwdata[sp_pkg::CTRL_MODE_LSB +: 2]; // RQ1
                mproc_r <= i_pwdata[sp_pkg::CTRL_MPROC];
                ren_r <= i_pwdata[sp_pkg::CTRL_REN];
                tb8_r <= i_pwdata[sp_pkg::CTRL_TB8];
            end
            ti_r <= ti_set || (wr_ctrl ? i_pwdata[sp_pkg::CTRL_TI] : ti_r); // RQ6
            ri_r <= ri_set || (wr_ctrl ? i_pwdata[sp_pkg::CTRL_RI] : ri_r); // RQ7
            if (rx_done && rx_keep && mode_r != sp_pkg::SP_MODE_SHIFT) begin
                rb8_r <= mode_r[1] ? rx_sh_r[8] : rxd_s_r; // RQ5
            end else if (wr_ctrl) begin
                rb8_r <= i_pwdata[sp_pkg::CTRL_RB8];
            end
        end
    end

    // ==========================================================
    // Interrupt status, cleared by read; set wins over clear
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            ists_r <= sp_pkg::RST_IRQ;
            o_irq <= 1'b0;
        end else begin
            ists_r <= (rd_ists ? 2'h0 : ists_r) | {ti_set, ri_set};
            o_irq <= |(ists_r & imask_r);
        end
    end

    // ==========================================================
    // Receive pin synchroniser and edge history
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            rxd_m_r <= 1'b1;
            rxd_s_r <= 1'b1;
            rxd_prev_r <= 1'b1;
        end else begin
            rxd_m_r <= i_rxd;
            rxd_s_r <= rxd_m_r;
            rxd_prev_r <= rxd_s_r;
        end
    end

    // Bit-rate tick from the core clock
    sp_rate_gen u_rate ( // RQ16
        .i_sys_clk(i_sys_clk),
        .i_reset(i_reset),
        .i_fixed(mode_r == sp_pkg::SP_MODE_FIX9),
        .i_dbl(aux_r[sp_pkg::AUX_DBL]),
        .i_bd(rsel_r[sp_pkg::RSEL_BD]),
        .i_reload({relh_r[1:0], rell_r}), // RQ10
        .i_timer_ovf(i_timer_ovf),
        .o_tick(tick)
    );

    // Shift-mode divider: clock/12 per bit
    assign m0_step = (m0_cnt_r == sp_pkg::M0_LAST);
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            m0_cnt_r <= 4'h0;
        end else if (m0_start || m0_step) begin
            m0_cnt_r <= 4'h0; // RQ1
        end else begin
            m0_cnt_r <= m0_cnt_r + 4'h1;
        end
    end

    // ==========================================================
    // Transmitter
    assign stop_idx = mode_r[1] ? sp_pkg::STOP_IDX9 : sp_pkg::STOP_IDX8;
    assign nine = mode_r[1] ? tb8_r : 1'b1;
    assign m0_start = (wr_buf && mode_r == sp_pkg::SP_MODE_SHIFT)
        || (rx_st_r == sp_pkg::SP_ST_IDLE && mode_r == sp_pkg::SP_MODE_SHIFT
            && ren_r && !ri_r && tx_st_r == sp_pkg::SP_ST_IDLE);
    assign ti_set = (tx_st_r == sp_pkg::SP_ST_SHIFT && m0_step
            && tx_bit_r == sp_pkg::M0_BIT_LAST)
        || (tx_st_r == sp_pkg::SP_ST_FRAME && tick && tx_sub_r == sp_pkg::SUB_LAST
            && tx_bit_r == stop_idx - 4'h1);

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_st_r <= sp_pkg::SP_ST_IDLE;
            tx_fr_r <= 11'h7ff;
            tx_bit_r <= 4'h0;
            tx_sub_r <= 4'h0;
        end else if (wr_buf) begin
            tx_bit_r <= 4'h0; // RQ8
            tx_sub_r <= 4'h0;
            if (mode_r == sp_pkg::SP_MODE_SHIFT) begin
                tx_st_r <= sp_pkg::SP_ST_SHIFT;
                tx_fr_r <= {3'h7, i_pwdata[7:0]};
            end else begin
                tx_st_r <= sp_pkg::SP_ST_FRAME;
                tx_fr_r <= {1'b1, nine, i_pwdata[7:0], 1'b0}; // RQ4 RQ17
            end
        end else begin
            case (tx_st_r)
                sp_pkg::SP_ST_SHIFT: begin
                    if (m0_step) begin
                        tx_fr_r <= {1'b1, tx_fr_r[10:1]};
                        tx_bit_r <= tx_bit_r + 4'h1;
                        if (tx_bit_r == sp_pkg::M0_BIT_LAST) begin
                            tx_st_r <= sp_pkg::SP_ST_IDLE;
                        end
                    end
                end
                sp_pkg::SP_ST_FRAME: begin
                    if (tick) begin
                        tx_sub_r <= tx_sub_r + 4'h1;
                        if (tx_sub_r == sp_pkg::SUB_LAST) begin
                            tx_fr_r <= {1'b1, tx_fr_r[10:1]}; // RQ17
                            tx_bit_r <= tx_bit_r + 4'h1;
                            if (tx_bit_r == stop_idx) begin
                                tx_st_r <= sp_pkg::SP_ST_IDLE;
                            end
                        end
                    end
                end
                default: tx_st_r <= sp_pkg::SP_ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Receiver
    assign rx_done = (rx_st_r == sp_pkg::SP_ST_SHIFT && m0_step
            && rx_bit_r == sp_pkg::M0_BIT_LAST)
        || (rx_st_r == sp_pkg::SP_ST_FRAME && tick && rx_sub_r == sp_pkg::SUB_MID
            && rx_bit_r == stop_idx);
    assign rx_keep = !(mode_r[1] && mproc_r && !rx_sh_r[8]); // RQ18
    assign ri_set = rx_done && rx_keep; // RQ7

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            rx_st_r <= sp_pkg::SP_ST_IDLE;
            rx_sh_r <= 9'h000;
            rx_bit_r <= 4'h0;
            rx_sub_r <= 4'h0;
        end else if (!ren_r) begin
            rx_st_r <= sp_pkg::SP_ST_IDLE; // RQ3
        end else begin
            case (rx_st_r)
                sp_pkg::SP_ST_IDLE: begin
                    rx_bit_r <= 4'h0;
                    rx_sub_r <= 4'h0;
                    if (m0_start && !wr_buf) begin
                        rx_st_r <= sp_pkg::SP_ST_SHIFT; // RQ3
                    end else if (mode_r != sp_pkg::SP_MODE_SHIFT
                        && rxd_prev_r && !rxd_s_r) begin
                        rx_st_r <= sp_pkg::SP_ST_FRAME; // RQ3
                    end
                end
                sp_pkg::SP_ST_SHIFT: begin
                    if (m0_cnt_r == sp_pkg::M0_SAMPLE) begin
                        rx_sh_r <= {rxd_s_r, rx_sh_r[8:1]};
                    end
                    if (m0_step) begin
                        rx_bit_r <= rx_bit_r + 4'h1;
                        if (rx_bit_r == sp_pkg::M0_BIT_LAST) begin
                            rx_st_r <= sp_pkg::SP_ST_IDLE;
                        end
                    end
                end
                sp_pkg::SP_ST_FRAME: begin
                    if (tick) begin
                        rx_sub_r <= rx_sub_r + 4'h1;
                        if (rx_sub_r == sp_pkg::SUB_LAST) begin
                            rx_bit_r <= rx_bit_r + 4'h1;
                        end
                        if (rx_sub_r == sp_pkg::SUB_MID) begin
                            if ((rx_bit_r == 4'h0 && rxd_s_r) || rx_bit_r == stop_idx) begin
                                rx_st_r <= sp_pkg::SP_ST_IDLE; // RQ17
                            end else if (rx_bit_r != 4'h0) begin
                                rx_sh_r <= {rxd_s_r, rx_sh_r[8:1]}; // RQ17
                            end
                        end
                    end
                end
                default: rx_st_r <= sp_pkg::SP_ST_IDLE;
            endcase
        end
    end

    // Receive buffer, separate from the transmit shifter
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            rxbuf_r <= sp_pkg::RST_BUF;
        end else if (ri_set) begin
            rxbuf_r <= mode_r[1] ? rx_sh_r[7:0] : rx_sh_r[8:1]; // RQ9
        end
    end

    // ==========================================================
    // Pin registers: shift mode clock on transmit pin, data on receive pin
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_txd <= 1'b1;
            o_rxd_out <= 1'b1;
            o_rxd_oe <= 1'b0;
        end else begin
            if (tx_st_r == sp_pkg::SP_ST_SHIFT || rx_st_r == sp_pkg::SP_ST_SHIFT) begin
                o_txd <= (m0_cnt_r >= sp_pkg::M0_HALF); // RQ1
            end else if (tx_st_r == sp_pkg::SP_ST_FRAME) begin
                o_txd <= tx_fr_r[0]; // RQ17
            end else begin
                o_txd <= 1'b1; // RQ17
            end
            o_rxd_oe <= (tx_st_r == sp_pkg::SP_ST_SHIFT);
            o_rxd_out <= (tx_st_r == sp_pkg::SP_ST_SHIFT) ? tx_fr_r[0] : 1'b1;
        end
    end

    // ==========================================================
    // Checks
    a_rx_enable_gate: assert property ( // RQ3
        (!ren_r && rx_st_r == sp_pkg::SP_ST_IDLE) |=> rx_st_r == sp_pkg::SP_ST_IDLE)
        else $error("receiver started while disabled");
    a_tx_ninth_bit: assert property ( // RQ4
        (wr_buf && mode_r[1]) |=> tx_fr_r[9] == $past(tb8_r))
        else $error("ninth transmit bit wrong");
    a_rx_ninth_copy: assert property ( // RQ5
        (rx_done && rx_keep && mode_r[1]) |=> rb8_r == $past(rx_sh_r[8]))
        else $error("ninth receive bit not copied");
    a_ti_at_stop: assert property ( // RQ6
        (tx_st_r == sp_pkg::SP_ST_FRAME && tick && tx_sub_r == sp_pkg::SUB_LAST
            && tx_bit_r == stop_idx - 4'h1 && !wr_buf) |=> ti_r && tx_fr_r[0])
        else $error("transmit flag not set at stop start");
    a_ri_mid_stop: assert property ( // RQ7
        (ri_set && !ri_r) |=> $rose(ri_r) ##0 rx_st_r == sp_pkg::SP_ST_IDLE)
        else $error("receive flag not raised on completion");
    a_buf_write_start: assert property ( // RQ8
        wr_buf |=> tx_st_r != sp_pkg::SP_ST_IDLE ##0 tx_bit_r == 4'h0)
        else $error("buffer write did not start transmission");
    a_buf_read_rx: assert property ( // RQ9
        (acc && !o_pready && !i_pwrite && algn && idx == sp_pkg::IDX_BUF && !ri_set)
            |=> o_prdata[7:0] == $past(rxbuf_r))
        else $error("buffer read did not return receive buffer");
    a_m0_period: assert property ( // RQ1
        (m0_step && !m0_start) ##1 !m0_start [*8] ##1 !m0_start [*3]
            |=> m0_cnt_r == sp_pkg::M0_LAST)
        else $error("shift mode divider not twelve");
    a_mproc_filter: assert property ( // RQ18
        (rx_done && mode_r[1] && mproc_r && !rx_sh_r[8] && !ri_r && !wr_ctrl) |=> !ri_r)
        else $error("filtered frame raised receive flag");
endmodule // sp_serial_port

// ---- dv/sp_remote.sv ----
// Purpose: Remote serial device driving the receive pin
// Assumes: Bit period is given in system clock cycles
// Notes:   Line idles high between frames
`timescale 1ns/1ps
module sp_remote (
    input wire logic i_sys_clk,
    output logic o_line
);
    // ========
    // Idle level
    initial o_line = 1'b1;
    // Frame sender, bit 0 of the frame first
    task automatic send(input logic [10:0] fr, input int n, input int p);
        for (int i = 0; i < n; i++) begin
            @(posedge i_sys_clk);
            o_line <= fr[i];
            repeat (p - 1) @(posedge i_sys_clk);
        end
    endtask
endmodule // sp_remote

// ---- dv/tb_serial_port_uart_baud_gen.sv ----
// Purpose: Self-checking bench for the serial port
// Assumes: One wait state on every register access
// Notes:   Expected bytes are kept in a queue model
`timescale 1ns/1ps
module tb_serial_port_uart_baud_gen;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, se, txd, rxd, rxo, rxoe, irq;
    logic [7:0] d;
    logic [7:0] rxq[$];
    logic [7:0] ctl[4] = '{8'h98, 8'h98, 8'h88, 8'hb8};
    int err_count = 0;
    int comparisons = 0;
    logic [1:0] tcnt = 2'h0;
    // ========
    // Clock and design
    always #12.5 i_sys_clk = ~i_sys_clk;
    // Timer overflow pulse every fourth clock
    always @(posedge i_sys_clk) tcnt <= tcnt + 2'h1;
    sp_serial_port sp_serial_port_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_timer_ovf(tcnt == 2'h3), .i_rxd(rxd), .o_txd(txd), .o_rxd_out(rxo),
        .o_rxd_oe(rxoe), .o_irq(irq));
    sp_remote sp_remote_i (.i_sys_clk(i_sys_clk), .o_line(rxd));
    // ========
    // Compare and count
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Register access, held until the answer
    task automatic apb(input logic w, input logic [9:0] ix, input logic [7:0] v);
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {ix, 2'b00};
        pwdata <= {24'h00_0000, v};
        @(posedge i_sys_clk);
        pen <= 1'b1;
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // Frame on the transmit pin, sampled mid-bit
    task automatic txchk(input logic [10:0] fr, input int n, input int p);
        for (int k = 0; k < 999 && txd !== 1'b0; k++) @(negedge i_sys_clk);
        repeat (p / 2) @(negedge i_sys_clk);
        for (int i = 0; i < n; i++) begin
            chk("txd bit", {31'h0, txd}, {31'h0, fr[i]});
            repeat (p) @(negedge i_sys_clk);
        end
    endtask
    task automatic print_verdict;
        if (err_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ========
    // Watchdog
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        err_count++;
        print_verdict;
    end
    // Main sequence
    initial begin
        void'($urandom(32'h9668_b463));
        repeat (6) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        apb(0, sp_pkg::IDX_RELL, 8'h00);
        chk("reload low", rd, 32'h0000_00d9);
        apb(0, sp_pkg::IDX_RELH, 8'h00);
        chk("reload high", rd, 32'h0000_0003);
        apb(0, 10'h3ff, 8'h00);
        chk("unmapped", {31'h0, se}, 32'h0000_0001);
        apb(1, sp_pkg::IDX_AUX, 8'h00);
        apb(1, sp_pkg::IDX_IMASK, 8'h03);
        apb(1, sp_pkg::IDX_CTRL, 8'h98);
        d = 8'($urandom);
        apb(1, sp_pkg::IDX_BUF, d);
        txchk({2'b11, d, 1'b0}, 11, 64);
        apb(0, sp_pkg::IDX_CTRL, 8'h00);
        chk("tx flag", {31'h0, rd[1]}, 32'h0000_0001);
        chk("irq", {31'h0, irq}, 32'h0000_0001);
        apb(0, sp_pkg::IDX_ISTS, 8'h00);
        chk("tx status", {31'h0, rd[1]}, 32'h0000_0001);
        repeat (3) @(posedge i_sys_clk);
        chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
        apb(1, sp_pkg::IDX_AUX, 8'h01);
        // Receive: plain, ninth bit set, disabled, filtered
        for (int i = 0; i < 4; i++) begin
            d = 8'($urandom);
            apb(1, sp_pkg::IDX_CTRL, ctl[i]);
            sp_remote_i.send({1'b1, i == 1, d, 1'b0}, 11, 32);
            if (i < 2) rxq.push_back(d);
            repeat (4) @(posedge i_sys_clk);
            apb(0, sp_pkg::IDX_CTRL, 8'h00);
            chk("rx flag", {31'h0, rd[0]}, {31'h0, i < 2});
            if (i < 2) chk("rx ninth", {31'h0, rd[2]}, {31'h0, i == 1});
            apb(0, sp_pkg::IDX_BUF, 8'h00);
            if (i < 2) chk("rx buffer", rd, {24'h0, rxq.pop_front()});
        end
        // 8-bit frame from the reload generator
        apb(1, sp_pkg::IDX_RELL, 8'hfe);
        apb(1, sp_pkg::IDX_RSEL, 8'h80);
        apb(1, sp_pkg::IDX_CTRL, 8'h40);
        // Let the generator wrap once onto the new reload
        repeat (2100) @(posedge i_sys_clk);
        d = 8'($urandom);
        apb(1, sp_pkg::IDX_BUF, d);
        txchk({2'b11, d, 1'b0}, 10, 64);
        // Variable 9-bit frame from timer overflow, one tick per pulse
        apb(1, sp_pkg::IDX_RSEL, 8'h00);
        apb(1, sp_pkg::IDX_CTRL, 8'hc8);
        d = 8'($urandom);
        apb(1, sp_pkg::IDX_BUF, d);
        txchk({2'b11, d, 1'b0}, 11, 64);
        // Shift mode: data on the receive pin, twelve clocks a bit
        apb(1, sp_pkg::IDX_CTRL, 8'h00);
        d = 8'($urandom);
        apb(1, sp_pkg::IDX_BUF, d);
        repeat (6) @(negedge i_sys_clk);
        chk("shift enable", {31'h0, rxoe}, 32'h0000_0001);
        for (int i = 0; i < 8; i++) begin
            chk("shift data", {31'h0, rxo}, {31'h0, d[i]});
            repeat (12) @(negedge i_sys_clk);
        end
        apb(0, sp_pkg::IDX_CTRL, 8'h00);
        chk("shift tx flag", {31'h0, rd[1]}, 32'h0000_0001);
        print_verdict;
    end
endmodule // tb_serial_port_uart_baud_gen
